//--- pvcs_pkg.sv
// package of register offsets, field layouts, reset values and timing counts for the pll sequencer
package pvcs_pkg;
    // ------------------------------------------------------------
    // register offsets (8-bit configuration port addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PLL_HOLD_RESET_ADDR = 8'h5c;
    localparam logic [7:0] OSC_TUNE_CONTROL_ADDR = 8'h5d;
    localparam logic [7:0] OSC_TUNE_STATUS_ADDR = 8'h5e;
    localparam logic [7:0] CONVERTER_CAL_RUN_ADDR = 8'h61;
    localparam logic [7:0] OSC_FREQ_TRIM_ADDR = 8'h59;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PLL_HOLD_RESET_RST = 8'h00;
    localparam logic [7:0] OSC_TUNE_CONTROL_RST = 8'h40;
    localparam logic [7:0] CONVERTER_CAL_RUN_RST = 8'h01;
    localparam logic [6:0] OSC_FREQ_TRIM_RST = 7'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PLL_HOLD_BIT = 0;
    localparam int TUNE_ENABLE_BIT = 0;
    localparam int SETTLE_LSB = 4;
    localparam int SETTLE_MSB = 6;
    localparam int TUNE_DONE_BIT = 0;
    localparam int CAL_RUN_BIT = 0;
    localparam int TRIM_MSB = 6;
    // ------------------------------------------------------------
    // timing: settle wait = (code + 1) * SETTLE_STEP_NS, counted at the core clock
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SETTLE_STEP_NS = 320;
    localparam int SETTLE_STEP_CYC_INT = (SETTLE_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [11:0] SETTLE_STEP_CYC = 12'(SETTLE_STEP_CYC_INT);
    localparam logic [6:0] TRIM_MID = 7'h40;
    // ------------------------------------------------------------
    // tuning engine states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TUNE_IDLE,
        TUNE_HELD,
        TUNE_APPLY,
        TUNE_SETTLE,
        TUNE_JUDGE,
        TUNE_DONE
    } pvcs_tune_e;
endpackage : pvcs_pkg

//--- pvcs_settle_timer.sv
// settle-wait timer for the oscillator tuning engine
`timescale 1ns/1ps
module pvcs_settle_timer
    import pvcs_pkg::*;
(
    input wire logic clock, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic start, // one-cycle pulse: begin a wait
    input wire logic [2:0] settleSel, // settle-select code
    output logic expired // one-cycle pulse when the wait ends
);
    logic [14:0] count_q;
    logic [14:0] count_d;
    logic expired_q;
    logic expired_d;

    // ------------------------------------------------------------
    // wait length grows linearly with the code, never zero
    // ------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        expired_d = 1'b0;
        if (start) begin
            count_d = 15'({3'h0, settleSel} + 4'h1) * 15'(SETTLE_STEP_CYC); // RQ3 RQ18
        end else if (count_q != 15'h0000) begin
            count_d = count_q - 15'h0001;
            expired_d = (count_q == 15'h0001);
        end
    end

    // registers only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 15'h0000;
            expired_q <= 1'b0;
        end else begin
            count_q <= count_d;
            expired_q <= expired_d;
        end
    end

    assign expired = expired_q;
endmodule : pvcs_settle_timer

//--- pvcs_sequencer.sv
// pll hold, oscillator tuning engine and converter calibration run control
// Summary of operation
// [RQ1] pll hold bit 0 at 0x5c, reset 0, holds pll and tuning engine in reset.
// [RQ2] software clears pll hold after programming dividers, bias and tuning control.
// [RQ3] settle-select bits 6:4, reset 4; larger code gives longer settle wait.
// [RQ4] tuning enable is bit 0; tuning control resets to 0x40.
// [RQ5] with tuning enabled, calibration starts when pll hold is written back to 0.
// [RQ6] the engine trims oscillator frequency automatically to centre it.
// [RQ7] software changes tuning control only while pll hold is 1.
// [RQ8] status bit 0 reads 1 when tuning done or skipped; bits 7:1 zero.
// [RQ9] software leaves the trim alone until the complete flag reads 1.
// [RQ10] calibration run bit 0 at 0x61, reset 1; 0 holds calibration in reset.
// [RQ11] clearing calibration run also resets core and serial link clock dividers.
// [RQ12] software clears calibration run before changing marked calibration registers.
// [RQ13] software sets calibration run before setting the serial link enable.
// [RQ14] software clears serial link enable before clearing calibration run.
// [RQ15] software writes reserved bits with their reset values.
// [RQ16] seven-bit trim at 0x59 bits 6:0, readable and writable for restore.
// [RQ17] complete flag reads 0 while held with tuning enabled and while running.
// [RQ18] settle wait counted in clock cycles, fixed cycles per code step.
`timescale 1ns/1ps
module pvcs_sequencer
    import pvcs_pkg::*;
(
    input wire logic clock, // core clock, 100 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic cfgWrite, // configuration port write strobe
    input wire logic cfgRead, // configuration port read strobe
    input wire logic [7:0] cfgAddr, // configuration port address
    input wire logic [7:0] cfgWdata, // configuration port write data
    input wire logic oscAbove, // comparator: oscillator above target frequency
    output logic [7:0] cfgRdata, // read data, valid the cycle after cfgRead
    output logic pllReset, // holds the analog pll in reset
    output logic [6:0] oscFreqTrim, // trim code to the oscillator
    output logic tuneBusy, // tuning engine running
    output logic calReset, // holds converter calibration in reset
    output logic coreDivReset, // resets core clock divider
    output logic linkDivReset // resets serial link clock divider
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    // software-visible register fields
    logic pllHold_q;
    logic pllHold_d;
    logic [2:0] settleSel_q;
    logic [2:0] settleSel_d;
    logic tuneEnable_q;
    logic tuneEnable_d;
    logic calRun_q;
    logic calRun_d;
    logic [6:0] trim_q;
    logic [6:0] trim_d;
    // engine status and the registered read data
    logic done_q;
    logic done_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    // engine state and the trim bit under trial
    pvcs_tune_e state_q;
    pvcs_tune_e state_d;
    logic [2:0] bitIdx_q;
    logic [2:0] bitIdx_d;
    // engine to timer handshake and decoded events
    logic timerStart;
    logic timerExpired;
    logic holdRelease;
    logic engineActive;

    // a write that clears the hold bit while it was set starts the engine when tuning is enabled
    assign holdRelease = cfgWrite && (cfgAddr == PLL_HOLD_RESET_ADDR) && pllHold_q
        && !cfgWdata[PLL_HOLD_BIT]; // RQ5

    // the engine owns the trim from the first trial bit to the last judgement
    assign engineActive = (state_q == TUNE_APPLY) || (state_q == TUNE_SETTLE)
        || (state_q == TUNE_JUDGE);

    // ------------------------------------------------------------
    // register images as software sees them; reserved bits read zero
    // ------------------------------------------------------------
    logic [7:0] holdWord;
    logic [7:0] controlWord;
    logic [7:0] statusWord;
    logic [7:0] calRunWord;
    logic [7:0] trimWord;
    assign holdWord = {7'h00, pllHold_q};
    assign controlWord = {1'b0, settleSel_q, 3'h0, tuneEnable_q};
    assign statusWord = {7'h00, done_q}; // RQ8
    assign calRunWord = {7'h00, calRun_q};
    assign trimWord = {1'b0, trim_q}; // RQ16

    // ------------------------------------------------------------
    // register file: writes, trim ownership, read mux
    // ------------------------------------------------------------
    always_comb begin
        pllHold_d = pllHold_q;
        settleSel_d = settleSel_q;
        tuneEnable_d = tuneEnable_q;
        calRun_d = calRun_q;
        trim_d = trim_q;
        rdata_d = rdata_q;
        if (cfgWrite) begin
            case (cfgAddr)
                PLL_HOLD_RESET_ADDR: begin
                    pllHold_d = cfgWdata[PLL_HOLD_BIT]; // RQ1
                end
                OSC_TUNE_CONTROL_ADDR: begin
                    settleSel_d = cfgWdata[SETTLE_MSB:SETTLE_LSB]; // RQ3
                    tuneEnable_d = cfgWdata[TUNE_ENABLE_BIT]; // RQ4
                end
                CONVERTER_CAL_RUN_ADDR: begin
                    calRun_d = cfgWdata[CAL_RUN_BIT]; // RQ10
                end
                OSC_FREQ_TRIM_ADDR: begin
                    // the engine owns the trim while running; port writes lose then
                    if (!engineActive) begin
                        trim_d = cfgWdata[TRIM_MSB:0]; // RQ16
                    end
                end
                default: begin
                end
            endcase
        end
        // engine trim steps: successive approximation, msb first
        case (state_q)
            TUNE_APPLY: begin
                // trial bit set and bits below it cleared: a stale restored value
                // in the low bits would bias every judgement made above them
                trim_d = (trim_q & (7'h7f << bitIdx_q)) | (7'h01 << bitIdx_q); // RQ6
            end
            TUNE_JUDGE: begin
                // keep the trial bit only while the oscillator is not yet fast
                if (oscAbove) begin
                    trim_d = trim_q & ~(7'h01 << bitIdx_q); // RQ6
                end
            end
            default: begin
            end
        endcase
        // a read in the same cycle as a write returns the old value
        if (cfgRead) begin
            case (cfgAddr)
                PLL_HOLD_RESET_ADDR: rdata_d = holdWord;
                OSC_TUNE_CONTROL_ADDR: rdata_d = controlWord;
                OSC_TUNE_STATUS_ADDR: rdata_d = statusWord; // RQ8
                CONVERTER_CAL_RUN_ADDR: rdata_d = calRunWord;
                OSC_FREQ_TRIM_ADDR: rdata_d = trimWord; // RQ16
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // tuning engine: idle, held, trim/settle/judge loop, done
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        bitIdx_d = bitIdx_q;
        done_d = done_q;
        timerStart = 1'b0;
        case (state_q)
            TUNE_IDLE: begin
                done_d = 1'b1; // skipped counts as complete
                if (pllHold_q) begin
                    state_d = TUNE_HELD;
                end
            end
            TUNE_HELD: begin
                // a held engine with tuning on has not yet finished a new run
                done_d = !tuneEnable_q; // RQ17
                if (holdRelease) begin
                    if (tuneEnable_q) begin
                        state_d = TUNE_APPLY; // RQ5
                        bitIdx_d = 3'h6;
                        done_d = 1'b0; // RQ17
                    end else begin
                        state_d = TUNE_IDLE;
                        done_d = 1'b1; // RQ8
                    end
                end
            end
            TUNE_APPLY: begin
                timerStart = 1'b1;
                state_d = TUNE_SETTLE;
            end
            TUNE_SETTLE: begin
                // the comparator is trusted only once the pll has settled on the trial
                if (timerExpired) begin
                    state_d = TUNE_JUDGE; // RQ3
                end
            end
            TUNE_JUDGE: begin
                if (bitIdx_q == 3'h0) begin
                    state_d = TUNE_DONE;
                end else begin
                    bitIdx_d = bitIdx_q - 3'h1;
                    state_d = TUNE_APPLY;
                end
            end
            TUNE_DONE: begin
                // one cycle here so the complete flag rises as busy falls
                done_d = 1'b1; // RQ8
                state_d = TUNE_IDLE;
            end
            default: begin
                state_d = TUNE_IDLE;
            end
        endcase
        // re-asserting the hold aborts any run and clears completion when tuning is enabled
        if (pllHold_d && !pllHold_q) begin
            state_d = TUNE_HELD; // RQ1
            done_d = !tuneEnable_d; // RQ17
        end
    end

    // ------------------------------------------------------------
    // settle timer
    // ------------------------------------------------------------
    pvcs_settle_timer uTimer (
        .clock(clock),
        .rst_n(rst_n),
        .start(timerStart),
        .settleSel(settleSel_q),
        .expired(timerExpired)
    );

    // ------------------------------------------------------------
    // state registers only
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pllHold_q <= PLL_HOLD_RESET_RST[PLL_HOLD_BIT];
            settleSel_q <= OSC_TUNE_CONTROL_RST[SETTLE_MSB:SETTLE_LSB];
            tuneEnable_q <= OSC_TUNE_CONTROL_RST[TUNE_ENABLE_BIT];
            calRun_q <= CONVERTER_CAL_RUN_RST[CAL_RUN_BIT];
            trim_q <= OSC_FREQ_TRIM_RST;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            state_q <= TUNE_IDLE;
            bitIdx_q <= 3'h0;
        end else begin
            pllHold_q <= pllHold_d;
            settleSel_q <= settleSel_d;
            tuneEnable_q <= tuneEnable_d;
            calRun_q <= calRun_d;
            trim_q <= trim_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            state_q <= state_d;
            bitIdx_q <= bitIdx_d;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops (one-cycle lag on the resets is harmless)
    // ------------------------------------------------------------
    logic pllReset_q;
    logic pllReset_d;
    logic busy_q;
    logic busy_d;
    logic calReset_q;
    logic calReset_d;
    logic coreDiv_q;
    logic coreDiv_d;
    logic linkDiv_q;
    logic linkDiv_d;
    logic [6:0] trimOut_q;
    logic [6:0] trimOut_d;

    // next values of the output flops; all divider holds come from one bit
    // so the core and the link divider can never leave reset apart
    always_comb begin
        pllReset_d = pllHold_q; // RQ1
        busy_d = engineActive;
        calReset_d = !calRun_q; // RQ10
        coreDiv_d = !calRun_q; // RQ11
        linkDiv_d = !calRun_q; // RQ11
        trimOut_d = trim_q;
    end

    // output registers only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pllReset_q <= 1'b0;
            busy_q <= 1'b0;
            calReset_q <= 1'b0;
            coreDiv_q <= 1'b0;
            linkDiv_q <= 1'b0;
            trimOut_q <= 7'h00;
        end else begin
            pllReset_q <= pllReset_d;
            busy_q <= busy_d;
            calReset_q <= calReset_d;
            coreDiv_q <= coreDiv_d;
            linkDiv_q <= linkDiv_d;
            trimOut_q <= trimOut_d;
        end
    end

    // ports come straight from the flops above
    assign cfgRdata = rdata_q;
    assign pllReset = pllReset_q;
    assign tuneBusy = busy_q;
    assign calReset = calReset_q;
    assign coreDivReset = coreDiv_q;
    assign linkDivReset = linkDiv_q;
    assign oscFreqTrim = trimOut_q;
endmodule : pvcs_sequencer

//--- pvcs_sva.sv
// port-level assertions for the pll hold, tuning engine and calibration run logic
`timescale 1ns/1ps
module pvcs_sva
    import pvcs_pkg::*;
(
    input wire logic clock, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic cfgWrite, // write strobe
    input wire logic cfgRead, // read strobe
    input wire logic [7:0] cfgAddr, // address
    input wire logic [7:0] cfgWdata, // write data
    input wire logic oscAbove, // comparator
    input wire logic [7:0] cfgRdata, // read data
    input wire logic pllReset, // pll held
    input wire logic [6:0] oscFreqTrim, // trim code
    input wire logic tuneBusy, // engine running
    input wire logic calReset, // calibration held
    input wire logic coreDivReset, // core divider held
    input wire logic linkDivReset // link divider held
);
    // ----------------------------------------
    // run length counter
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    int busyLen_q;
    int busyLen_d;
    // counts consecutive busy cycles; a plain repetition would unroll far too long
    always_comb busyLen_d = tuneBusy ? busyLen_q + 1 : 0;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) busyLen_q <= 0;
        else busyLen_q <= busyLen_d;
    end
    // status read taken while the engine was still running
    sequence sStatusRdBusy;
        cfgRead && cfgAddr == OSC_TUNE_STATUS_ADDR && tuneBusy ##1 tuneBusy;
    endsequence
    a_hold_pin: assert property (cfgWrite && cfgAddr == PLL_HOLD_RESET_ADDR |->
        ##2 pllReset == $past(cfgWdata[0], 2)) else $error("hold pin wrong");
    a_cal_pin: assert property (cfgWrite && cfgAddr == CONVERTER_CAL_RUN_ADDR |->
        ##2 calReset == !$past(cfgWdata[0], 2)) else $error("cal pin wrong");
    a_div_tie: assert property (coreDivReset == calReset && linkDivReset == calReset)
        else $error("divider resets differ");
    a_busy_done: assert property (sStatusRdBusy |-> cfgRdata[0] == 1'b0)
        else $error("done read during run");
    a_status_rsvd: assert property ($past(cfgRead) && $past(cfgAddr) == OSC_TUNE_STATUS_ADDR
        |-> cfgRdata[7:1] == 7'h00) else $error("status upper bits set");
    a_run_start: assert property ($rose(tuneBusy) |-> $fell(pllReset))
        else $error("run not started by hold release");
    a_run_len: assert property ($fell(tuneBusy) && !pllReset |->
        busyLen_q >= 224 && busyLen_q <= 1830) else $error("run length off");
    a_held_idle: assert property (pllReset ##1 pllReset |-> !tuneBusy)
        else $error("busy while held");
    a_trim_idle: assert property ((cfgWrite && cfgAddr == OSC_FREQ_TRIM_ADDR && !tuneBusy)
        ##1 !tuneBusy |-> ##1 oscFreqTrim == $past(cfgWdata[6:0], 2)) else $error("trim lost");
    a_unmapped: assert property (cfgRead && !(cfgAddr inside {8'h59, 8'h5c, 8'h5d, 8'h5e, 8'h61})
        |=> cfgRdata == 8'h00) else $error("unmapped read nonzero");
endmodule : pvcs_sva
bind pvcs_sequencer pvcs_sva i_pvcs_sva (.clock, .rst_n, .cfgWrite, .cfgRead, .cfgAddr,
    .cfgWdata, .oscAbove, .cfgRdata, .pllReset, .oscFreqTrim, .tuneBusy, .calReset,
    .coreDivReset, .linkDivReset);

//--- tb_top.sv
// self-checking bench for the pll sequencer register port and tuning engine
`timescale 1ns/1ps
module tb_top
    import pvcs_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cfgWrite = 1'b0;
    logic cfgRead = 1'b0;
    logic [7:0] cfgAddr = 8'h00;
    logic [7:0] cfgWdata = 8'h00;
    logic oscAbove = 1'b0;
    logic [7:0] cfgRdata;
    logic [6:0] oscFreqTrim;
    logic pllReset, tuneBusy, calReset, coreDivReset, linkDivReset;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int len0, len2;
    localparam logic [6:0] TARGET = 7'h2a;
    pvcs_sequencer i_pvcs_sequencer (.clock, .rst_n, .cfgWrite, .cfgRead, .cfgAddr,
        .cfgWdata, .oscAbove, .cfgRdata, .pllReset, .oscFreqTrim, .tuneBusy, .calReset,
        .coreDivReset, .linkDivReset);
    initial forever #5 clock = ~clock;
    // comparator stand-in: the oscillator runs fast whenever trim exceeds the target
    always @(posedge clock) oscAbove <= (oscFreqTrim > TARGET);
    // hang guard, far above two tuning runs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            stop_test();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        cfgWrite <= 1'b1;
        cfgAddr <= a;
        cfgWdata <= d;
        @(posedge clock);
        cfgWrite <= 1'b0;
    endtask : wr
    // read data lands on the taking edge, so look just after it
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        cfgRead <= 1'b1;
        cfgAddr <= a;
        @(posedge clock);
        cfgRead <= 1'b0;
        #1;
        chk(16'(cfgRdata), 16'(e), "read");
    endtask : rdc
    task automatic tune(input logic [2:0] code, output int len);
        wr(PLL_HOLD_RESET_ADDR, 8'h01);
        wr(OSC_TUNE_CONTROL_ADDR, {1'b0, code, 4'h1});
        rdc(OSC_TUNE_STATUS_ADDR, 8'h00);
        chk({15'h0, pllReset}, 16'h1, "hold pin");
        wr(PLL_HOLD_RESET_ADDR, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        chk({15'h0, tuneBusy}, 16'h1, "busy");
        // same fixed intrusion in every run keeps the length difference exact
        wr(OSC_FREQ_TRIM_ADDR, 8'h55);
        rdc(OSC_TUNE_STATUS_ADDR, 8'h00);
        len = 0;
        while (tuneBusy === 1'b1 && len < 3000) begin
            @(posedge clock);
            #1;
            len++;
        end
        rdc(OSC_TUNE_STATUS_ADDR, 8'h01);
        rdc(OSC_FREQ_TRIM_ADDR, {1'b0, TARGET});
        chk(16'(oscFreqTrim), 16'(TARGET), "trim pin");
    endtask : tune
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rdc(PLL_HOLD_RESET_ADDR, 8'h00);
        rdc(OSC_TUNE_CONTROL_ADDR, 8'h40);
        rdc(OSC_TUNE_STATUS_ADDR, 8'h01);
        rdc(CONVERTER_CAL_RUN_ADDR, 8'h01);
        rdc(OSC_FREQ_TRIM_ADDR, 8'h00);
        rdc(8'h5f, 8'h00);
        chk({15'h0, calReset}, 16'h0, "cal pin");
        wr(CONVERTER_CAL_RUN_ADDR, 8'h00);
        @(posedge clock);
        #1;
        chk({13'h0, calReset, coreDivReset, linkDivReset}, 16'h7, "div hold");
        wr(CONVERTER_CAL_RUN_ADDR, 8'h01);
        @(posedge clock);
        #1;
        chk({13'h0, calReset, coreDivReset, linkDivReset}, 16'h0, "div run");
        rdc(CONVERTER_CAL_RUN_ADDR, 8'h01);
        // tuning disabled: release skips the run and still reports done
        wr(PLL_HOLD_RESET_ADDR, 8'h01);
        wr(OSC_TUNE_CONTROL_ADDR, 8'h40);
        wr(PLL_HOLD_RESET_ADDR, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        chk({15'h0, tuneBusy}, 16'h0, "skip busy");
        rdc(OSC_TUNE_STATUS_ADDR, 8'h01);
        wr(OSC_FREQ_TRIM_ADDR, 8'h15);
        rdc(OSC_FREQ_TRIM_ADDR, 8'h15);
        chk(16'(oscFreqTrim), 16'h15, "restore pin");
        tune(3'd0, len0);
        tune(3'd2, len2);
        chk(16'(len2 - len0), 16'd448, "settle");
        stop_test();
    end
endmodule : tb_top
